// ===== hdl/pofs_pkg.sv
// constants, register map and carrier types for the partner operation supervisor
// assumes a 20 MHz clock and a plain address/strobe register port
// Summary of operation
// - single operation: both units enabled and feeding, tie switch open
// - both loads below connect threshold: start linking after configured delay
// - linking: tracking off, match dc voltages, close tie, one unit off
// - no match in time: tracking back on, retry matching after delay
// - deactivating or self-ack fault in single operation: healthy unit off too
// - self-ack fault: voltages match, close tie, restart healthy unit
// - voltages still differ after time: restart healthy unit, retry after delay
// - permanent deactivating fault: skip comparison, close tie, restart healthy unit
// - manual ack in fault-linked operation moves to normal linked operation
// - night picks next active unit; applied when both leave night
// - linked load above disconnect threshold: go to single operation
// - active unit in linked operation alternates day by day
// - linking completes only if voltage difference below maximum parameter
// - fault messages only while unit is switched on, else fault free
// - deactivating fault opens output contactor and dc input switch
// - deactivating fault auto-acks after time unless dc voltage dropped
// - at most 3 restart attempts, then latched permanent shutdown
// - attempt counter cleared after configured fault-free run time
// - latched deactivating fault clears by reset or manual ack, regenerates
// - self-ack fault opens contactor only, restarts when cause gone
// - self-ack fault clears by manual ack or reset, regenerates if persisting
// - signalling fault touches nothing, clears with cause, regenerates after ack
// - leaving linked: running unit off, then tie open, then both on
package pofs_pkg;
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [1:0]  MAX_ATTEMPTS = 2'h3;
  localparam int unsigned CTRL_ACK_BIT = 0;

  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_CONN_THR = 4'h1;
  localparam logic [3:0] OFS_DISC_THR = 4'h2;
  localparam logic [3:0] OFS_MAX_DV   = 4'h3;
  localparam logic [3:0] OFS_CONN_DLY = 4'h4;
  localparam logic [3:0] OFS_MATCH_T  = 4'h5;
  localparam logic [3:0] OFS_MATCH_RT = 4'h6;
  localparam logic [3:0] OFS_FMATCH_T = 4'h7;
  localparam logic [3:0] OFS_FRETRY   = 4'h8;
  localparam logic [3:0] OFS_ACK_T    = 4'h9;
  localparam logic [3:0] OFS_RUN_CLR  = 4'ha;
  localparam logic [3:0] OFS_STATUS   = 4'hb;
  localparam logic [3:0] OFS_FAULT    = 4'hc;

  typedef struct packed {
    logic [15:0] conn_thr, disc_thr, max_dv, conn_dly, match_t, match_rt;
    logic [15:0] fmatch_t, fretry, ack_t, run_clr;
  } pofs_cfg_s;

  localparam pofs_cfg_s CFG_RST = '{16'h0028, 16'h0050, 16'h000a, 16'h0064, 16'h0032,
                                    16'h0064, 16'h0032, 16'h0064, 16'h0032, 16'h2328};

  typedef enum logic [3:0] {
    SEQ_SINGLE, SEQ_CONN_DLY, SEQ_MATCH, SEQ_BACKOFF, SEQ_LINKED, SEQ_SEP_OFF,
    SEQ_SEP_OPEN, SEQ_FLT_OFF, SEQ_FLT_CMP, SEQ_FLT_TIE, SEQ_FLT_RETRY, SEQ_FLT_LINKED
  } pofs_seq_e;

  typedef struct packed {
    logic [1:0][7:0]  load;
    logic [1:0][11:0] vdc;
    logic [1:0]       deact_cause, sa_cause, sig_cause, dc_drop, night;
  } pofs_plant_s;

  typedef struct packed {
    logic [1:0] run_en, mppt_en, output_contactor, dc_input_switch;
    logic [1:0] deact_flag, perm_flag, sa_flag, sig_flag;
    logic       tie_close;
  } pofs_out_s;
endpackage : pofs_pkg

// ===== hdl/pofs_supervisor.sv
// partner operation and fault supervisor for two grid inverter units
// plant inputs are asynchronous and pass two flops; index 0/1 names the unit;
// power off-on is rst_i, manual acknowledgement is a write to the control register
`timescale 1ns/1ps
module pofs_supervisor #(
  parameter int unsigned TICK_CYCLES = pofs_pkg::TICK_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [3:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [31:0]           rdata_o,
  input  wire pofs_pkg::pofs_plant_s plant_i,
  output pofs_pkg::pofs_out_s        ctl_o
);
  import pofs_pkg::*;

  typedef struct packed {
    pofs_plant_s      sy1;
    pofs_plant_s      sy2;
    pofs_cfg_s        cfg;
    pofs_seq_e        seq;
    logic [15:0]      tmr;
    logic             fside;
    logic             active;
    logic             sel_next;
    logic             night_seen;
    logic [1:0]       deact;
    logic [1:0]       perm;
    logic [1:0]       sa;
    logic [1:0]       sig;
    logic [1:0]       drop_seen;
    logic [1:0][1:0]  attempts;
    logic [1:0][15:0] ack_tmr;
    logic [1:0][15:0] run_tmr;
    logic [31:0]      tick_cnt;
    logic             tick;
    logic [31:0]      rdata;
    pofs_out_s        out;
  } pofs_state_s;

  pofs_state_s q_q;
  pofs_state_s q_d;

  function automatic logic [1:0] pofs_onehot(input logic s);
    return s ? 2'b10 : 2'b01;
  endfunction : pofs_onehot

  function automatic logic pofs_vmatch(input logic [11:0] a,
                                       input logic [11:0] b,
                                       input logic [15:0] lim);
    logic [11:0] d;
    d = (a > b) ? (a - b) : (b - a);
    return {4'h0, d} < lim;
  endfunction : pofs_vmatch

  function automatic logic pofs_expired(input logic [15:0] t, input logic [15:0] lim);
    return t >= lim;
  endfunction : pofs_expired

  pofs_plant_s p;
  logic        ack;
  logic        low_load;
  logic [1:0]  faulty;
  logic        f;
  logic        h;

  assign p        = q_q.sy2;
  assign ack      = wr_i && (addr_i == OFS_CTRL) && wdata_i[CTRL_ACK_BIT];
  assign low_load = ({8'h00, p.load[0]} < q_q.cfg.conn_thr) &&
                    ({8'h00, p.load[1]} < q_q.cfg.conn_thr);
  assign faulty   = q_q.deact | q_q.sa;
  assign f        = q_q.fside;
  assign h        = ~q_q.fside;

  always_comb begin
    q_d     = q_q;
    q_d.sy1 = plant_i;
    q_d.sy2 = q_q.sy1;

    // coarse timebase keeps the 16-bit timers good for hours
    q_d.tick = 1'b0;
    if (q_q.tick_cnt >= TICK_CYCLES - 1) begin
      q_d.tick_cnt = '0;
      q_d.tick     = 1'b1;
    end else begin
      q_d.tick_cnt = q_q.tick_cnt + 32'h1;
    end

    if (wr_i) begin
      case (addr_i)
        OFS_CONN_THR: q_d.cfg.conn_thr = wdata_i[15:0];
        OFS_DISC_THR: q_d.cfg.disc_thr = wdata_i[15:0];
        OFS_MAX_DV:   q_d.cfg.max_dv   = wdata_i[15:0];
        OFS_CONN_DLY: q_d.cfg.conn_dly = wdata_i[15:0];
        OFS_MATCH_T:  q_d.cfg.match_t  = wdata_i[15:0];
        OFS_MATCH_RT: q_d.cfg.match_rt = wdata_i[15:0];
        OFS_FMATCH_T: q_d.cfg.fmatch_t = wdata_i[15:0];
        OFS_FRETRY:   q_d.cfg.fretry   = wdata_i[15:0];
        OFS_ACK_T:    q_d.cfg.ack_t    = wdata_i[15:0];
        OFS_RUN_CLR:  q_d.cfg.run_clr  = wdata_i[15:0];
        default: ;
      endcase
    end

    q_d.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        OFS_CONN_THR: q_d.rdata = {16'h0000, q_q.cfg.conn_thr};
        OFS_DISC_THR: q_d.rdata = {16'h0000, q_q.cfg.disc_thr};
        OFS_MAX_DV:   q_d.rdata = {16'h0000, q_q.cfg.max_dv};
        OFS_CONN_DLY: q_d.rdata = {16'h0000, q_q.cfg.conn_dly};
        OFS_MATCH_T:  q_d.rdata = {16'h0000, q_q.cfg.match_t};
        OFS_MATCH_RT: q_d.rdata = {16'h0000, q_q.cfg.match_rt};
        OFS_FMATCH_T: q_d.rdata = {16'h0000, q_q.cfg.fmatch_t};
        OFS_FRETRY:   q_d.rdata = {16'h0000, q_q.cfg.fretry};
        OFS_ACK_T:    q_d.rdata = {16'h0000, q_q.cfg.ack_t};
        OFS_RUN_CLR:  q_d.rdata = {16'h0000, q_q.cfg.run_clr};
        OFS_STATUS:   q_d.rdata = {20'h00000, q_q.seq, q_q.out.tie_close,
                                   q_q.night_seen, q_q.sel_next, q_q.active,
                                   q_q.fside, 3'h0};
        OFS_FAULT:    q_d.rdata = {16'h0000,
                                   2'h0, q_q.attempts[1], q_q.perm[1], q_q.deact[1],
                                   q_q.sa[1], q_q.sig[1],
                                   2'h0, q_q.attempts[0], q_q.perm[0], q_q.deact[0],
                                   q_q.sa[0], q_q.sig[0]};
        default:      q_d.rdata = '0;
      endcase
    end

    for (int i = 0; i < 2; i++) begin
      // new faults are only seen on a unit that is sequenced on
      if (!p.sig_cause[i] || ack) begin
        q_d.sig[i] = 1'b0;
      end
      if (p.sig_cause[i] && q_q.out.run_en[i]) begin
        q_d.sig[i] = 1'b1;
      end

      if (!p.sa_cause[i] || ack) begin
        q_d.sa[i] = 1'b0;
      end
      if (p.sa_cause[i] && q_q.out.run_en[i]) begin
        q_d.sa[i] = 1'b1;
      end

      if (q_q.deact[i] && !q_q.perm[i]) begin
        if (p.dc_drop[i]) begin
          q_d.drop_seen[i] = 1'b1;
        end
        if (q_q.tick) begin
          q_d.ack_tmr[i] = q_q.ack_tmr[i] + 16'h1;
        end
        if (pofs_expired(q_q.ack_tmr[i], q_q.cfg.ack_t)) begin
          // a deep dc sag during the fault forbids the automatic restart
          if (q_q.drop_seen[i] || p.dc_drop[i]) begin
            q_d.perm[i] = 1'b1;
          end else begin
            q_d.deact[i]    = 1'b0;
            q_d.attempts[i] = q_q.attempts[i] + 2'h1;
          end
        end
      end

      if (ack) begin
        q_d.deact[i]    = 1'b0;
        q_d.perm[i]     = 1'b0;
        q_d.attempts[i] = 2'h0;
      end

      if (p.deact_cause[i] && q_q.out.run_en[i] && !q_q.deact[i]) begin
        q_d.deact[i]     = 1'b1;
        q_d.ack_tmr[i]   = '0;
        q_d.drop_seen[i] = 1'b0;
        if (q_q.attempts[i] == MAX_ATTEMPTS) begin
          q_d.perm[i] = 1'b1;
        end
      end

      if (q_q.out.output_contactor[i] && q_q.attempts[i] != 2'h0 && !q_q.deact[i]) begin
        if (q_q.tick) begin
          q_d.run_tmr[i] = q_q.run_tmr[i] + 16'h1;
        end
        if (pofs_expired(q_q.run_tmr[i], q_q.cfg.run_clr)) begin
          q_d.attempts[i] = 2'h0;
          q_d.run_tmr[i]  = '0;
        end
      end else begin
        q_d.run_tmr[i] = '0;
      end
    end

    // one decision per night, applied when both units wake up
    if (p.night == 2'b11 && !q_q.night_seen) begin
      q_d.night_seen = 1'b1;
      q_d.sel_next   = ~q_q.active;
    end else if (p.night == 2'b00 && q_q.night_seen) begin
      q_d.night_seen = 1'b0;
      q_d.active     = q_q.sel_next;
    end

    if (q_q.tick) begin
      q_d.tmr = q_q.tmr + 16'h1;
    end

    case (q_q.seq)
      SEQ_SINGLE, SEQ_CONN_DLY, SEQ_MATCH, SEQ_BACKOFF: begin
        if (|faulty) begin
          q_d.fside = faulty[1];
          q_d.seq   = SEQ_FLT_OFF;
          q_d.tmr   = '0;
        end else if (!low_load) begin
          if (q_q.seq != SEQ_SINGLE) begin
            q_d.seq = SEQ_SINGLE;
            q_d.tmr = '0;
          end
        end else if (q_q.seq == SEQ_SINGLE) begin
          q_d.seq = SEQ_CONN_DLY;
          q_d.tmr = '0;
        end else if (q_q.seq == SEQ_CONN_DLY) begin
          if (pofs_expired(q_q.tmr, q_q.cfg.conn_dly)) begin
            q_d.seq = SEQ_MATCH;
            q_d.tmr = '0;
          end
        end else if (q_q.seq == SEQ_MATCH) begin
          if (pofs_vmatch(p.vdc[0], p.vdc[1], q_q.cfg.max_dv)) begin
            q_d.seq = SEQ_LINKED;
            q_d.tmr = '0;
          end else if (pofs_expired(q_q.tmr, q_q.cfg.match_t)) begin
            q_d.seq = SEQ_BACKOFF;
            q_d.tmr = '0;
          end
        end else if (pofs_expired(q_q.tmr, q_q.cfg.match_rt)) begin
          q_d.seq = SEQ_MATCH;
          q_d.tmr = '0;
        end
      end
      SEQ_LINKED: begin
        if (faulty[q_q.active] && !faulty[~q_q.active]) begin
          q_d.active = ~q_q.active;
        end else if ({8'h00, p.load[q_q.active]} > q_q.cfg.disc_thr) begin
          q_d.seq = SEQ_SEP_OFF;
          q_d.tmr = '0;
        end
      end
      SEQ_SEP_OFF: begin
        if (q_q.tick) begin
          q_d.seq = SEQ_SEP_OPEN;
          q_d.tmr = '0;
        end
      end
      SEQ_SEP_OPEN: begin
        if (q_q.tick) begin
          q_d.seq = SEQ_SINGLE;
          q_d.tmr = '0;
        end
      end
      SEQ_FLT_OFF: begin
        q_d.seq = q_q.perm[f] ? SEQ_FLT_TIE : SEQ_FLT_CMP;
        q_d.tmr = '0;
      end
      SEQ_FLT_CMP: begin
        if (!faulty[f]) begin
          q_d.seq = SEQ_SINGLE;
          q_d.tmr = '0;
        end else if (pofs_vmatch(p.vdc[0], p.vdc[1], q_q.cfg.max_dv)) begin
          q_d.seq = SEQ_FLT_TIE;
          q_d.tmr = '0;
        end else if (pofs_expired(q_q.tmr, q_q.cfg.fmatch_t)) begin
          q_d.seq = SEQ_FLT_RETRY;
          q_d.tmr = '0;
        end
      end
      SEQ_FLT_TIE: begin
        q_d.seq = SEQ_FLT_LINKED;
        q_d.tmr = '0;
      end
      SEQ_FLT_RETRY: begin
        if (!faulty[f]) begin
          q_d.seq = SEQ_SINGLE;
          q_d.tmr = '0;
        end else if (pofs_expired(q_q.tmr, q_q.cfg.fretry)) begin
          q_d.seq = SEQ_FLT_OFF;
          q_d.tmr = '0;
        end
      end
      SEQ_FLT_LINKED: begin
        if (ack) begin
          q_d.active = h;
          q_d.seq    = SEQ_LINKED;
          q_d.tmr    = '0;
        end
      end
      default: begin
        q_d.seq = SEQ_SINGLE;
        q_d.tmr = '0;
      end
    endcase

    // the faulty unit keeps its enable so a cleared fault can restart it
    case (q_d.seq)
      SEQ_SINGLE, SEQ_CONN_DLY, SEQ_BACKOFF, SEQ_FLT_RETRY: begin
        q_d.out.run_en    = 2'b11;
        q_d.out.mppt_en   = 2'b11;
        q_d.out.tie_close = 1'b0;
      end
      SEQ_MATCH: begin
        q_d.out.run_en    = 2'b11;
        q_d.out.mppt_en   = 2'b00;
        q_d.out.tie_close = 1'b0;
      end
      SEQ_LINKED: begin
        q_d.out.run_en    = pofs_onehot(q_d.active);
        q_d.out.mppt_en   = pofs_onehot(q_d.active);
        q_d.out.tie_close = 1'b1;
      end
      SEQ_SEP_OFF: begin
        q_d.out.run_en    = 2'b00;
        q_d.out.mppt_en   = 2'b00;
        q_d.out.tie_close = 1'b1;
      end
      SEQ_SEP_OPEN: begin
        q_d.out.run_en    = 2'b00;
        q_d.out.mppt_en   = 2'b00;
        q_d.out.tie_close = 1'b0;
      end
      SEQ_FLT_OFF, SEQ_FLT_CMP: begin
        q_d.out.run_en    = pofs_onehot(q_d.fside);
        q_d.out.mppt_en   = 2'b00;
        q_d.out.tie_close = 1'b0;
      end
      SEQ_FLT_TIE: begin
        q_d.out.run_en    = pofs_onehot(q_d.fside);
        q_d.out.mppt_en   = 2'b00;
        q_d.out.tie_close = 1'b1;
      end
      SEQ_FLT_LINKED: begin
        q_d.out.run_en    = 2'b11;
        q_d.out.mppt_en   = pofs_onehot(~q_d.fside);
        q_d.out.tie_close = 1'b1;
      end
      default: begin
        q_d.out.run_en    = 2'b00;
        q_d.out.mppt_en   = 2'b00;
        q_d.out.tie_close = 1'b0;
      end
    endcase

    q_d.out.output_contactor = q_d.out.run_en & ~q_d.deact & ~q_d.sa;
    q_d.out.dc_input_switch  = ~q_d.deact;
    q_d.out.deact_flag       = q_d.deact & q_d.out.run_en;
    q_d.out.perm_flag        = q_d.perm & q_d.out.run_en;
    q_d.out.sa_flag          = q_d.sa & q_d.out.run_en;
    q_d.out.sig_flag         = q_d.sig & q_d.out.run_en;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q     <= '0;
      q_q.cfg <= CFG_RST;
    end else begin
      q_q <= q_d;
    end
  end

  assign rdata_o = q_q.rdata;
  assign ctl_o   = q_q.out;
endmodule : pofs_supervisor

// ===== testbench/pofs_partner_model.sv
// far side: both units' dc regulation and the shared tie switch
// assumes the bench sets targets on want_i; matching moves one count per clock
`timescale 1ns/1ps
module pofs_partner_model (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  conv_i,
  input  wire pofs_pkg::pofs_plant_s want_i,
  input  wire pofs_pkg::pofs_out_s   ctl_i,
  output pofs_pkg::pofs_plant_s      plant_o
);
  import pofs_pkg::*;
  logic [1:0][11:0] v_q = '0;
  logic [11:0]      mid;
  assign mid = 12'((13'(want_i.vdc[0]) + 13'(want_i.vdc[1])) >> 1);
  // conv_i low models both units unable to regulate, to force match timeouts
  always_ff @(posedge clk_i) begin
    for (int u = 0; u < 2; u++) begin
      if (rst_i || ctl_i.mppt_en[u]) begin
        v_q[u] <= want_i.vdc[u];
      end else if (ctl_i.tie_close) begin
        v_q[u] <= mid;
      end else if (conv_i && v_q[u] != mid) begin
        v_q[u] <= (v_q[u] < mid) ? v_q[u] + 12'h1 : v_q[u] - 12'h1;
      end
    end
  end
  always_comb begin
    plant_o     = want_i;
    plant_o.vdc = v_q;
    for (int u = 0; u < 2; u++) begin
      plant_o.load[u] = (ctl_i.run_en[u] && ctl_i.output_contactor[u]) ?
                        want_i.load[u] : 8'h0;
    end
  end
endmodule : pofs_partner_model

// ===== testbench/pofs_supervisor_assertions.sv
// checker on the supervisor ports: switch states per fault class, separation
// order, idle read port; bound from the bench top, one clock, reset disables all
`timescale 1ns/1ps
module pofs_supervisor_assertions (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic [3:0]            addr_i,
  input wire logic                  rd_i,
  input wire logic [31:0]           rdata_o,
  input wire pofs_pkg::pofs_plant_s plant_i,
  input wire pofs_pkg::pofs_out_s   ctl_o
);
  import pofs_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  deact_opens_a: assert property (
    (ctl_o.deact_flag[1] || ctl_o.perm_flag[1]) |->
      !ctl_o.output_contactor[1] && !ctl_o.dc_input_switch[1])
    else $error("deactivating fault with a switch closed");
  ack_wait_a: assert property (
    $fell(ctl_o.output_contactor[1]) && ctl_o.deact_flag[1] |->
      !ctl_o.output_contactor[1] [*8])
    else $error("restart before acknowledge time");
  sa_keeps_dc_a: assert property (
    ctl_o.sa_flag[0] && !ctl_o.deact_flag[0] && !ctl_o.perm_flag[0] |->
      !ctl_o.output_contactor[0] && ctl_o.dc_input_switch[0])
    else $error("self-ack fault switch state wrong");
  sig_harmless_a: assert property (
    $rose(ctl_o.sig_flag[0]) && $past(ctl_o.run_en[0]) && !ctl_o.sa_flag[0]
      && !ctl_o.deact_flag[0] |-> $stable(ctl_o.output_contactor) && $stable(ctl_o.run_en))
    else $error("signalling fault moved the sequence");
  off_quiet_a: assert property (
    ((ctl_o.deact_flag | ctl_o.perm_flag | ctl_o.sa_flag | ctl_o.sig_flag)
      & ~ctl_o.run_en) == 2'b00)
    else $error("fault shown on a unit that is off");
  rd_idle_a: assert property (
    !$past(rd_i) || $past(addr_i) > 4'hc |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  sep_order_a: assert property (
    $fell(ctl_o.tie_close) |-> $past(ctl_o.run_en) == 2'b00)
    else $error("tie opened with a unit running");
  link_load_a: assert property (
    $fell(ctl_o.mppt_en[0]) && ctl_o.run_en == 2'b11 |->
      16'(plant_i.load[0]) < CFG_RST.conn_thr && 16'(plant_i.load[1]) < CFG_RST.conn_thr)
    else $error("matching started at high load");
  cover property ($rose(ctl_o.tie_close));
  cover property ($fell(ctl_o.tie_close));
  cover property (ctl_o.perm_flag[1]);
endmodule : pofs_supervisor_assertions

// ===== testbench/tb_pofs_supervisor.sv
// bench for the partner supervisor: registers, linking, night swap, faults
// assumes the partner model on the plant side and TICK_CYCLES cut to 4
`timescale 1ns/1ps
module tb_pofs_supervisor;
  import pofs_pkg::*;
  logic        clk_i, rst_i, wr_i, rd_i, conv;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, st, seed;
  pofs_plant_s want, plant_i;
  pofs_out_s   ctl_o;
  int          fail_count, comparisons;
  pofs_supervisor #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .plant_i(plant_i),
    .ctl_o(ctl_o));
  pofs_partner_model u_far (.clk_i(clk_i), .rst_i(rst_i), .conv_i(conv), .want_i(want),
    .ctl_i(ctl_o), .plant_o(plant_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [15:0] dflt(input int i);
    return CFG_RST[(10 - i) * 16 +: 16];
  endfunction : dflt
  function automatic logic [1:0] onehot(input logic a);
    return a ? 2'b10 : 2'b01;
  endfunction : onehot
  function automatic logic cond(input int k);
    case (k)
      0: return ctl_o.tie_close;
      1: return !ctl_o.tie_close;
      2: return ctl_o.mppt_en == 2'b00;
      3: return ctl_o.mppt_en == 2'b11;
      4: return !ctl_o.output_contactor[0];
      default: return ctl_o.run_en == 2'b11;
    endcase
  endfunction : cond
  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wt(input int k);
    for (int n = 0; cond(k) !== 1'b1; n++) begin
      @(negedge clk_i);
      if (n > 4000) begin
        fail_count++;
        give_verdict();
      end
    end
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= {16'h0, d};
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask : rd
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    logic [15:0] r;
    logic        a0;
    seed = 32'h1714;
    {rst_i, wr_i, rd_i, addr_i, wdata_i, conv} = {3'b100, 4'h0, 32'h0, 1'b1};
    want = '0;
    want.load = {8'h70, 8'h70};
    want.vdc = {12'h300, 12'h400};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(32'(ctl_o), 32'h1fe00);
    for (int i = 1; i < 11; i++) begin
      rd(4'(i), st);
      chk(st, {16'h0, dflt(i)});
    end
    rd(4'hd, st);
    chk(st, 32'h0);
    // shorter delays and ack time, longer match timeouts, keep each scenario to a few thousand cycles
    wr(4'h4, 16'h2);
    wr(4'h5, 16'h80);
    wr(4'h6, 16'h2);
    wr(4'h7, 16'h80);
    wr(4'h8, 16'h2);
    wr(4'h9, 16'h4);
    r = 16'h4000 | 16'(rnd() & 32'hfff);
    wr(4'ha, r);
    rd(4'ha, st);
    chk(st, {16'h0, r});
    wr(4'hb, 16'hffff);
    rd(4'hb, st);
    chk(st & 32'hf80, 32'h0);
    @(posedge clk_i);
    want.sig_cause[0] <= 1'b1;
    repeat (6) @(negedge clk_i);
    chk(32'(ctl_o), 32'h1fe02);
    @(posedge clk_i);
    want.sig_cause[0] <= 1'b0;
    conv <= 1'b0;
    want.load <= {8'h10, 8'h10};
    wt(2);
    wt(3);
    chk(32'(ctl_o.tie_close), 32'h0);
    wt(2);
    chk(32'(ctl_o.sig_flag), 32'h0);
    @(posedge clk_i);
    conv <= 1'b1;
    wt(0);
    rd(4'hb, st);
    chk(32'(st[11:8]), 32'd4);
    a0 = st[4];
    chk(32'(ctl_o.run_en), 32'(onehot(a0)));
    @(posedge clk_i);
    want.night <= 2'b11;
    repeat (8) @(posedge clk_i);
    want.night <= 2'b00;
    repeat (8) @(negedge clk_i);
    rd(4'hb, st);
    chk(32'(st[4]), 32'(!a0));
    chk(32'(ctl_o.run_en), 32'(onehot(!a0)));
    @(posedge clk_i);
    want.load <= {8'h60 | 8'(rnd() & 32'h1f), 8'h60 | 8'(rnd() & 32'h1f)};
    wt(1);
    wt(5);
    // loads read zero while both units were off, so a short connect delay may run first
    repeat (4) @(negedge clk_i);
    rd(4'hb, st);
    chk(32'(st[11:7]), 32'h0);
    @(posedge clk_i);
    want.sa_cause[0] <= 1'b1;
    wt(4);
    // the sequencer reacts one edge after the fault flag
    @(negedge clk_i);
    chk(32'(ctl_o.run_en), 32'h1);
    chk(32'({ctl_o.dc_input_switch[0], ctl_o.sa_flag[0]}), 32'h3);
    wt(0);
    wt(5);
    rd(4'hb, st);
    chk(32'(st[11:8]), 32'd11);
    @(posedge clk_i);
    want.load[1] <= 8'h10;
    wr(4'h0, 16'h1);
    repeat (3) @(negedge clk_i);
    rd(4'hb, st);
    chk(32'(st[11:8]), 32'd4);
    chk(32'({ctl_o.run_en, ctl_o.sa_flag}), 32'h8);
    @(posedge clk_i);
    want.sa_cause[0] <= 1'b0;
    want.load[1] <= 8'h70;
    wt(1);
    wt(5);
    @(posedge clk_i);
    conv <= 1'b0;
    want.deact_cause[1] <= 1'b1;
    st = 32'h0;
    for (int n = 0; n < 2000 && st[11] !== 1'b1; n++) begin
      rd(4'hc, st);
    end
    chk(32'(st[13:11]), 32'h7);
    wt(0);
    chk(32'({ctl_o.output_contactor[1], ctl_o.dc_input_switch[1]}), 32'h0);
    @(posedge clk_i);
    want.deact_cause[1] <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(4'h0, 16'h1);
    rd(4'hc, st);
    chk(32'(st[15:8]), 32'h0);
    // self-ack fault with frozen dc regulation: compare times out, healthy unit restarts
    wt(1);
    wt(5);
    @(posedge clk_i);
    want.sa_cause[1] <= 1'b1;
    wt(2);
    wt(5);
    rd(4'hb, st);
    chk(32'(st[11:7]), 32'h14);
    repeat (12) @(negedge clk_i);
    chk(32'(ctl_o.run_en), 32'h2);
    give_verdict();
  end
endmodule : tb_pofs_supervisor
bind pofs_supervisor pofs_supervisor_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .plant_i(plant_i), .ctl_o(ctl_o));
